// ==== hw/sbd_initiator.sv ====
/*
 initiator end: arbitrates, selects a target, answers req with ack.
 assumes one target end on the interface; bus inputs are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module sbd_initiator
  import sbd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  sbd_bus_if.initiator    bus,
  input  wire logic [2:0] my_id,
  input  wire logic [2:0] tgt_id,
  input  wire logic       rst_req,
  input  wire logic       atn_req,
  input  wire logic       go_valid,
  output logic            go_ready,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            par_err,
  output logic            connected
);
  typedef enum logic [6:0] {
    I_IDLE = 7'b000_0001,
    I_FREE = 7'b000_0010,
    I_ARB  = 7'b000_0100,
    I_SEL  = 7'b000_1000,
    I_CONN = 7'b001_0000,
    I_ACK  = 7'b010_0000,
    I_REL  = 7'b100_0000
  } sbd_istate_t;

  sbd_istate_t       st_q;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [7:0]        db_s;
  logic [7:0]        idb;
  logic [7:0]        tdb;
  logic [7:0]        higher;
  logic [CNT_W-1:0]  cnt_q;
  logic [7:0]        dout_q;
  logic [7:0]        dboe_q;
  logic [7:0]        rx_q;
  logic              rxv_q;
  logic              perr_q;
  logic              bsy_q;
  logic              sel_q;
  logic              ack_q;
  logic              dbp_oe_q;
  logic              gap_q;
  logic              take;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {bus.db, bus.dbp, bus.bsy, bus.sel, bus.rst, bus.ack, bus.atn,
               bus.msg, bus.cd, bus.io, bus.req};
      s2_q <= s1_q;
    end
  end

  assign db_s   = s2_q[17:10];
  assign idb    = 8'h01 << my_id;
  assign tdb    = 8'h01 << tgt_id;
  assign higher = db_s & ~((idb << 1) - 8'h01);
  assign take   = (st_q == I_CONN) && s2_q[8] && s2_q[0] && (s2_q[1] || tx_valid);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q     <= I_IDLE;
      cnt_q    <= '0;
      dout_q   <= DB_RESET;
      dboe_q   <= '0;
      dbp_oe_q <= 1'b0;
      bsy_q    <= 1'b0;
      sel_q    <= 1'b0;
      ack_q    <= 1'b0;
      gap_q    <= 1'b0;
    end else if (s2_q[6]) begin
      st_q     <= I_IDLE;
      dboe_q   <= '0;
      dbp_oe_q <= 1'b0;
      bsy_q    <= 1'b0;
      sel_q    <= 1'b0;
      ack_q    <= 1'b0;
      gap_q    <= 1'b0;
    end else begin
      unique case (st_q)
        I_IDLE: begin
          cnt_q <= CNT_W'(BUS_FREE_CYC);
          if (go_valid) begin
            st_q <= I_FREE;
          end
        end
        I_FREE: begin
          if (s2_q[8] || s2_q[7]) begin
            cnt_q <= CNT_W'(BUS_FREE_CYC);
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            // only our id bit, parity left released
            bsy_q  <= 1'b1;
            dout_q <= idb;
            dboe_q <= idb;
            cnt_q  <= CNT_W'(ARB_DELAY_CYC);
            st_q   <= I_ARB;
          end
        end
        I_ARB: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (higher != '0 || s2_q[7]) begin
            bsy_q  <= 1'b0;
            dboe_q <= '0;
            cnt_q  <= CNT_W'(BUS_FREE_CYC);
            st_q   <= I_FREE;
          end else begin
            sel_q    <= 1'b1;
            gap_q    <= 1'b0;
            dout_q   <= idb | tdb;
            dboe_q   <= 8'hFF;
            dbp_oe_q <= 1'b1;
            cnt_q    <= CNT_W'(SETTLE_CYC);
            st_q     <= I_SEL;
          end
        end
        I_SEL: begin
          // own busy lingers on the synced input, so target busy only counts
          // once busy has been seen low after our release
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            bsy_q <= 1'b0;
            if (!bsy_q && !s2_q[8]) begin
              gap_q <= 1'b1;
            end else if (s2_q[8] && gap_q) begin
              sel_q    <= 1'b0;
              dboe_q   <= '0;
              dbp_oe_q <= 1'b0;
              st_q     <= I_CONN;
            end
          end
        end
        I_CONN: begin
          if (!s2_q[8]) begin
            dboe_q   <= '0;
            dbp_oe_q <= 1'b0;
            st_q     <= I_IDLE;
          end else if (take) begin
            dout_q   <= tx_data;
            dboe_q   <= {8{!s2_q[1]}};
            dbp_oe_q <= !s2_q[1];
            cnt_q    <= CNT_W'(DESKEW_CYC);
            st_q     <= I_ACK;
          end else if (s2_q[1]) begin
            dboe_q   <= '0;
            dbp_oe_q <= 1'b0;
          end
        end
        I_ACK: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            ack_q <= 1'b1;
            st_q  <= I_REL;
          end
        end
        I_REL: begin
          if (!s2_q[0]) begin
            ack_q <= 1'b0;
            st_q  <= I_CONN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_q   <= DB_RESET;
      rxv_q  <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      rxv_q  <= take && s2_q[1] && !s2_q[6];
      perr_q <= take && s2_q[1] && !s2_q[6] && !sbd_par_ok(db_s, s2_q[9]);
      if (take && s2_q[1]) begin
        rx_q <= db_s;
      end
    end
  end

  assign go_ready     = (st_q == I_IDLE) && !s2_q[6];
  assign tx_ready     = take && !s2_q[1] && !s2_q[6];
  assign rx_valid     = rxv_q;
  assign rx_data      = rx_q;
  assign par_err      = perr_q;
  assign connected    = (st_q == I_CONN) || (st_q == I_ACK) || (st_q == I_REL);
  assign bus.i_db_o   = dout_q;
  assign bus.i_db_oe  = dboe_q;
  assign bus.i_dbp_o  = sbd_par(dout_q);
  assign bus.i_dbp_oe = dbp_oe_q;
  assign bus.i_bsy_oe = bsy_q;
  assign bus.i_sel_oe = sel_q;
  assign bus.i_rst_oe = rst_req;
  assign bus.i_ack_oe = ack_q;
  assign bus.i_atn_oe = atn_req && connected;
endmodule
`default_nettype wire

// ==== hw/sbd_pkg.sv ====
/*
 package for the parallel target bus drive: timing counts, phase codes, parity.
 assumes a 20 MHz ref_clk; all times are rounded up to whole cycles.
*/
`default_nettype none
package sbd_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DESKEW_NS     = 45;
  localparam int SETTLE_NS     = 400;
  localparam int BUS_FREE_NS   = 800;
  localparam int ARB_DELAY_NS  = 2400;
  localparam int DESKEW_CYC    = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_CYC  = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARB_DELAY_CYC = (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 6;
  localparam int FIFO_DEPTH    = 32;
  localparam int SYNC_W        = 18;

  // phase code is {msg, cd, io}
  typedef logic [2:0] sbd_phase_t;
  localparam sbd_phase_t PH_DATA_OUT = 3'h0;
  localparam sbd_phase_t PH_DATA_IN  = 3'h1;
  localparam sbd_phase_t PH_COMMAND  = 3'h2;
  localparam sbd_phase_t PH_STATUS   = 3'h3;
  localparam sbd_phase_t PH_MSG_OUT  = 3'h6;
  localparam sbd_phase_t PH_MSG_IN   = 3'h7;

  localparam logic [7:0] DB_RESET = 8'h00;

  function automatic logic sbd_par(input logic [7:0] b);
    return ~^b;
  endfunction

  function automatic logic sbd_par_ok(input logic [7:0] b, input logic p);
    return ^{b, p};
  endfunction
endpackage
`default_nettype wire

// ==== hw/sbd_bus_if.sv ====
/*
 interface joining target and initiator ends; lines are held in true level.
 assumes the bench adds nothing: a released line reads false (terminator).
*/
`timescale 1ns/10ps
`default_nettype none
interface sbd_bus_if;
  logic [7:0] t_db_o;
  logic       t_db_oe;
  logic       t_dbp_o;
  logic       t_bsy_oe;
  logic       t_rst_oe;
  logic [2:0] t_phase_o;
  logic       t_req_o;
  logic       t_ctl_oe;
  logic [7:0] i_db_o;
  logic [7:0] i_db_oe;
  logic       i_dbp_o;
  logic       i_dbp_oe;
  logic       i_bsy_oe;
  logic       i_sel_oe;
  logic       i_rst_oe;
  logic       i_ack_oe;
  logic       i_atn_oe;
  logic [7:0] db;
  logic       dbp;
  logic       bsy;
  logic       sel;
  logic       rst;
  logic       msg;
  logic       cd;
  logic       io;
  logic       req;
  logic       ack;
  logic       atn;

  // wired-or in true level: undriven means false
  assign db  = ({8{t_db_oe}} & t_db_o) | (i_db_oe & i_db_o);
  assign dbp = (t_db_oe & t_dbp_o) | (i_dbp_oe & i_dbp_o);
  assign bsy = t_bsy_oe | i_bsy_oe;
  assign sel = i_sel_oe;
  assign rst = t_rst_oe | i_rst_oe;
  assign msg = t_ctl_oe & t_phase_o[2];
  assign cd  = t_ctl_oe & t_phase_o[1];
  assign io  = t_ctl_oe & t_phase_o[0];
  assign req = t_ctl_oe & t_req_o;
  assign ack = i_ack_oe;
  assign atn = i_atn_oe;

  modport target (
    output t_db_o, t_db_oe, t_dbp_o, t_bsy_oe, t_rst_oe, t_phase_o, t_req_o, t_ctl_oe,
    input  db, dbp, bsy, sel, rst, msg, cd, io, req, ack, atn
  );
  modport initiator (
    output i_db_o, i_db_oe, i_dbp_o, i_dbp_oe, i_bsy_oe, i_sel_oe, i_rst_oe,
    output i_ack_oe, i_atn_oe,
    input  db, dbp, bsy, sel, rst, msg, cd, io, req, ack, atn
  );
endinterface
`default_nettype wire

// ==== hw/sbd_fifo.sv ====
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock; full and empty are exact.
*/
`timescale 1ns/10ps
`default_nettype none
module sbd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== hw/sbd_target.sv ====
/*
 target end of the parallel bus: answers selection, runs info phases, req/ack.
 assumes the initiator end keeps its own lines; bus inputs are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module sbd_target
  import sbd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  sbd_bus_if.target       bus,
  input  wire logic [2:0] my_id,
  input  wire logic       rst_req,
  input  wire logic       ph_valid,
  output logic            ph_ready,
  input  wire logic       ph_end,
  input  wire sbd_phase_t ph_code,
  input  wire logic [7:0] ph_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            selected,
  output logic            par_err,
  output logic            atn_seen,
  output logic            bus_rst_seen
);
  typedef enum logic [5:0] {
    T_IDLE  = 6'b00_0001,
    T_SELD  = 6'b00_0010,
    T_WAIT  = 6'b00_0100,
    T_SETUP = 6'b00_1000,
    T_REQ   = 6'b01_0000,
    T_REL   = 6'b10_0000
  } sbd_tstate_t;

  sbd_tstate_t      st_q;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [7:0]       db_s;
  logic             dbp_s;
  logic             bsy_s;
  logic             sel_s;
  logic             rst_s;
  logic             ack_s;
  logic             atn_s;
  logic [CNT_W-1:0] cnt_q;
  sbd_phase_t       ph_q;
  logic [7:0]       dout_q;
  logic             bsy_q;
  logic             ctl_q;
  logic             dboe_q;
  logic             req_q;
  logic             push_q;
  logic [7:0]       push_d_q;
  logic             sel_q;
  logic             perr_q;
  logic             fifo_rdy;
  logic             own_bit;

  // the first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {bus.db, bus.dbp, bus.bsy, bus.sel, bus.rst, bus.ack, bus.atn,
               bus.msg, bus.cd, bus.io, bus.req};
      s2_q <= s1_q;
    end
  end

  assign db_s  = s2_q[17:10];
  assign dbp_s = s2_q[9];
  assign bsy_s = s2_q[8];
  assign sel_s = s2_q[7];
  assign rst_s = s2_q[6];
  assign ack_s = s2_q[5];
  assign atn_s = s2_q[4];
  assign own_bit = db_s[my_id];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= T_IDLE;
      cnt_q  <= '0;
      ph_q   <= PH_DATA_OUT;
      dout_q <= DB_RESET;
      bsy_q  <= 1'b0;
      ctl_q  <= 1'b0;
      dboe_q <= 1'b0;
      req_q  <= 1'b0;
    end else if (rst_s) begin
      // bus reset clears everything the target drives except rst, which keeps following rst_req
      st_q   <= T_IDLE;
      bsy_q  <= 1'b0;
      ctl_q  <= 1'b0;
      dboe_q <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      unique case (st_q)
        T_IDLE: begin
          // selection only: sel with busy released; arbitration never matches
          if (sel_s && !bsy_s && own_bit && sbd_par_ok(db_s, dbp_s)) begin
            bsy_q <= 1'b1;
            st_q  <= T_SELD;
          end
        end
        T_SELD: begin
          if (!sel_s) begin
            st_q <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (ph_valid) begin
            if (ph_end) begin
              // hand the bus back: everything released
              bsy_q  <= 1'b0;
              ctl_q  <= 1'b0;
              dboe_q <= 1'b0;
              st_q   <= T_IDLE;
            end else begin
              ph_q   <= ph_code;
              ctl_q  <= 1'b1;
              dboe_q <= ph_code[0];
              dout_q <= ph_data;
              cnt_q  <= CNT_W'(SETTLE_CYC);
              st_q   <= T_SETUP;
            end
          end
        end
        T_SETUP: begin
          // settle data and phase lines before req; out bytes wait for fifo room
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (ph_q[0] || fifo_rdy) begin
            req_q <= 1'b1;
            st_q  <= T_REQ;
          end
        end
        T_REQ: begin
          if (ack_s) begin
            req_q <= 1'b0;
            st_q  <= T_REL;
          end
        end
        T_REL: begin
          if (!ack_s) begin
            st_q <= T_WAIT;
          end
        end
      endcase
    end
  end

  // receive path: byte sampled with ack, parity checked
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      push_q   <= 1'b0;
      push_d_q <= DB_RESET;
      perr_q   <= 1'b0;
    end else begin
      push_q <= (st_q == T_REQ) && ack_s && !ph_q[0] && !rst_s;
      perr_q <= (st_q == T_REQ) && ack_s && !ph_q[0] && !rst_s &&
                !sbd_par_ok(db_s, dbp_s);
      if ((st_q == T_REQ) && ack_s) begin
        push_d_q <= db_s;
      end
    end
  end

  // event and level outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= (st_q == T_IDLE) && !rst_s && sel_s && !bsy_s && own_bit &&
               sbd_par_ok(db_s, dbp_s);
    end
  end

  sbd_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (push_q),
    .in_ready  (fifo_rdy),
    .in_data   (push_d_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign ph_ready     = (st_q == T_WAIT) && !rst_s;
  assign selected     = sel_q;
  assign par_err      = perr_q;
  assign atn_seen     = atn_s;
  assign bus_rst_seen = rst_s;

  // target never arbitrates nor selects, so it never drives select
  assign bus.t_bsy_oe  = bsy_q;
  assign bus.t_rst_oe  = rst_req;
  assign bus.t_ctl_oe  = ctl_q;
  assign bus.t_phase_o = ph_q;
  assign bus.t_req_o   = req_q;
  assign bus.t_db_oe   = dboe_q;
  assign bus.t_db_o    = dout_q;
  assign bus.t_dbp_o   = sbd_par(dout_q);
endmodule
`default_nettype wire

// ==== dv/sbd_bus_props.sv ====
/*
 checker on the bus between the target and initiator ends.
 assumes it sits beside the bus interface and sees its true-level lines.
*/
`timescale 1ns/10ps
`default_nettype none
module sbd_bus_props #(
  parameter int INIT_ID = 7,
  parameter int TGT_ID  = 3
) (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       t_db_oe,
  input wire logic       t_bsy_oe,
  input wire logic       t_ctl_oe,
  input wire logic [2:0] t_phase_o,
  input wire logic [7:0] i_db_oe,
  input wire logic       i_dbp_o,
  input wire logic       i_dbp_oe,
  input wire logic       i_bsy_oe,
  input wire logic       i_sel_oe,
  input wire logic [7:0] db,
  input wire logic       dbp,
  input wire logic       bsy,
  input wire logic       sel,
  input wire logic       rst,
  input wire logic       io,
  input wire logic       req,
  input wire logic       ack
);
  localparam logic [7:0] ID_I = 8'h01 << INIT_ID;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_arb;
    i_bsy_oe && !sel && !t_bsy_oe;
  endsequence
  sequence s_sel_mine;
    sel && db[TGT_ID] && !bsy;
  endsequence
  sequence s_ack_answer;
    req ##[1:8] !req;
  endsequence
  chk_par_odd: assert property (t_db_oe |-> ^{db, dbp})
    else $error("target byte without odd parity");
  // the initiator sees the bus through two flops, so it gets a few cycles of grace
  chk_free_init: assert property ((!bsy && !sel)[*4] |-> i_db_oe == 8'h00 && !i_dbp_oe)
    else $error("initiator drives data in bus free");
  chk_free_tgt: assert property ((!bsy && !sel)[*2] |-> !t_db_oe && !t_ctl_oe)
    else $error("target drives lines in bus free");
  chk_arb_id: assert property (s_arb |-> i_db_oe == 8'h00 || i_db_oe == ID_I)
    else $error("arbitration drives more than own id bit");
  chk_arb_par: assert property (s_arb |-> !i_dbp_oe || i_dbp_o)
    else $error("parity driven false in arbitration");
  chk_sel_bsy: assert property (s_sel_mine |-> ##[1:6] t_bsy_oe)
    else $error("target did not answer its selection");
  chk_sel_cause: assert property ($rose(t_bsy_oe) |-> sel && db[TGT_ID])
    else $error("target busy without own selection");
  chk_tgt_quiet: assert property (sel |-> !t_db_oe && !t_ctl_oe)
    else $error("target drives lines while select is up");
  chk_req_phase: assert property ($rose(req) |-> t_bsy_oe && $stable(t_phase_o) && t_db_oe == io)
    else $error("request with unsettled phase or wrong data owner");
  chk_ack_answer: assert property ($rose(ack) |-> s_ack_answer)
    else $error("ack without request or request not withdrawn");
  chk_ack_drop: assert property ($fell(req) |-> ##[1:8] !ack)
    else $error("ack not released after request fell");
  chk_rst_idle: assert property (rst[*6] |-> !t_bsy_oe && !t_ctl_oe && !t_db_oe && !i_sel_oe && !i_bsy_oe)
    else $error("lines still driven during bus reset");
endmodule
`default_nettype wire

// ==== dv/scsi_target_bus_drive_tb_top.sv ====
/*
 self-checking bench: target and initiator ends joined by the bus interface.
 assumes the package, interface, fifo and both ends are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module scsi_target_bus_drive_tb_top
  import sbd_pkg::*;
  ();
  localparam int IID = 7;
  localparam int TID = 3;
  localparam logic [7:0] ID_BOTH = (8'h01 << IID) | (8'h01 << TID);
  logic ref_clk = 1'h0, resetn = 1'h0, perr_seen = 1'h0;
  logic t_ph_valid = 1'h0, t_ph_end = 1'h0, t_rx_ready = 1'h1, t_rst_req = 1'h0;
  logic n_rst_req = 1'h0, n_atn_req = 1'h0, n_go_valid = 1'h0, n_tx_valid = 1'h0;
  logic t_ph_ready, t_rx_valid, t_selected, t_par_err, t_atn_seen, t_rst_seen;
  logic n_go_ready, n_tx_ready, n_rx_valid, n_par_err, n_conn;
  logic [7:0] t_ph_data = 8'h00, n_tx_data = 8'h00;
  logic [7:0] t_rx_data, n_rx_data;
  sbd_phase_t t_ph_code = PH_DATA_OUT;
  sbd_phase_t in_ph [3] = '{PH_DATA_IN, PH_STATUS, PH_MSG_IN};
  sbd_phase_t out_ph [3] = '{PH_COMMAND, PH_DATA_OUT, PH_MSG_OUT};
  logic [7:0] pat [3] = '{8'h00, 8'ha5, 8'h80};
  int err_count = 0;
  int cmp_count = 0;
  int wn = 0;
  int k;

  sbd_bus_if bus ();
  sbd_target i_sbd_target (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .my_id(3'(TID)),
    .rst_req(t_rst_req), .ph_valid(t_ph_valid), .ph_ready(t_ph_ready), .ph_end(t_ph_end),
    .ph_code(t_ph_code), .ph_data(t_ph_data), .rx_valid(t_rx_valid), .rx_ready(t_rx_ready),
    .rx_data(t_rx_data), .selected(t_selected), .par_err(t_par_err), .atn_seen(t_atn_seen),
    .bus_rst_seen(t_rst_seen));
  sbd_initiator i_sbd_initiator (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
    .my_id(3'(IID)), .tgt_id(3'(TID)), .rst_req(n_rst_req), .atn_req(n_atn_req),
    .go_valid(n_go_valid), .go_ready(n_go_ready), .tx_valid(n_tx_valid), .tx_ready(n_tx_ready),
    .tx_data(n_tx_data), .rx_valid(n_rx_valid), .rx_data(n_rx_data), .par_err(n_par_err),
    .connected(n_conn));
  sbd_bus_props #(.INIT_ID(IID), .TGT_ID(TID)) i_sbd_bus_props (.ref_clk(ref_clk),
    .resetn(resetn), .t_db_oe(bus.t_db_oe), .t_bsy_oe(bus.t_bsy_oe), .t_ctl_oe(bus.t_ctl_oe),
    .t_phase_o(bus.t_phase_o), .i_db_oe(bus.i_db_oe), .i_dbp_o(bus.i_dbp_o),
    .i_dbp_oe(bus.i_dbp_oe), .i_bsy_oe(bus.i_bsy_oe), .i_sel_oe(bus.i_sel_oe), .db(bus.db),
    .dbp(bus.dbp), .bsy(bus.bsy), .sel(bus.sel), .rst(bus.rst), .io(bus.io), .req(bus.req),
    .ack(bus.ack));

  always #25 ref_clk = ~ref_clk;
  // sticky, since a stray parity pulse lasts one cycle only
  always @(posedge ref_clk) begin
    if (t_par_err || n_par_err) perr_seen <= 1'h1;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic to_chk(input logic ok);
    wn = 0;
    if (ok !== 1'h1) begin
      `CHK(ok, 1'h1)
      print_verdict();
    end
  endtask

  task automatic tgt_req(input sbd_phase_t code, input logic [7:0] data, input logic fin);
    @(posedge ref_clk);
    t_ph_valid <= 1'h1;
    t_ph_code  <= code;
    t_ph_data  <= data;
    t_ph_end   <= fin;
    do @(negedge ref_clk); while (!t_ph_ready && ++wn < 500);
    to_chk(t_ph_ready);
    @(posedge ref_clk);
    t_ph_valid <= 1'h0;
  endtask

  task automatic init_send(input logic [7:0] data);
    @(posedge ref_clk);
    n_tx_valid <= 1'h1;
    n_tx_data  <= data;
    do @(negedge ref_clk); while (!n_tx_ready && ++wn < 500);
    to_chk(n_tx_ready);
    @(posedge ref_clk);
    n_tx_valid <= 1'h0;
  endtask

  task automatic tgt_pop(input logic [7:0] data);
    do @(negedge ref_clk); while (!t_rx_valid && ++wn < 500);
    to_chk(t_rx_valid);
    `CHK(t_rx_data, data)
    @(posedge ref_clk);
  endtask

  task automatic t_select();
    int arb;
    arb = 0;
    @(posedge ref_clk);
    n_go_valid <= 1'h1;
    do @(negedge ref_clk); while (!n_go_ready && ++wn < 500);
    to_chk(n_go_ready);
    @(posedge ref_clk);
    n_go_valid <= 1'h0;
    do begin
      @(negedge ref_clk);
      arb += int'(bus.bsy);
      if (arb == 40 && bus.bsy && !bus.sel) `CHK(bus.db, 8'h01 << IID)
    end while (!bus.sel && ++wn < 500);
    to_chk(bus.sel);
    repeat (2) @(negedge ref_clk);
    `CHK({bus.dbp, bus.db}, {~^ID_BOTH, ID_BOTH})
    do @(negedge ref_clk); while (!t_selected && ++wn < 500);
    to_chk(t_selected);
    do @(negedge ref_clk); while ((bus.sel || !n_conn) && ++wn < 500);
    to_chk(!bus.sel && n_conn);
    `CHK({bus.t_bsy_oe, bus.i_bsy_oe}, 2'h2)
  endtask

  task automatic t_atn();
    @(posedge ref_clk);
    n_atn_req <= 1'h1;
    repeat (6) @(negedge ref_clk);
    `CHK({bus.atn, t_atn_seen}, 2'h3)
    @(posedge ref_clk);
    n_atn_req <= 1'h0;
    repeat (6) @(negedge ref_clk);
    `CHK({bus.atn, t_atn_seen}, 2'h0)
  endtask

  task automatic t_in(input sbd_phase_t code, input logic [7:0] data);
    tgt_req(code, data, 1'h0);
    do @(negedge ref_clk); while (!bus.req && ++wn < 500);
    to_chk(bus.req);
    `CHK({bus.msg, bus.cd, bus.io}, code)
    `CHK({bus.dbp, bus.db}, {~^data, data})
    do @(negedge ref_clk); while (!n_rx_valid && ++wn < 500);
    to_chk(n_rx_valid);
    `CHK(n_rx_data, data)
  endtask

  task automatic t_out(input sbd_phase_t code, input logic [7:0] data, input logic pop);
    tgt_req(code, 8'h00, 1'h0);
    do @(negedge ref_clk); while (!bus.req && ++wn < 500);
    to_chk(bus.req);
    `CHK({bus.msg, bus.cd, bus.io, bus.t_db_oe}, {code, 1'h0})
    init_send(data);
    if (pop) tgt_pop(data);
  endtask

  // fill the receive buffer, prove the stall, then drain in order
  task automatic t_fifo();
    @(posedge ref_clk);
    t_rx_ready <= 1'h0;
    for (k = 0; k < FIFO_DEPTH; k++) t_out(PH_DATA_OUT, 8'(k * 5 + 3), 1'h0);
    tgt_req(PH_DATA_OUT, 8'h00, 1'h0);
    repeat (40) @(negedge ref_clk);
    `CHK(bus.req, 1'h0)
    @(posedge ref_clk);
    t_rx_ready <= 1'h1;
    for (k = 0; k < FIFO_DEPTH; k++) tgt_pop(8'(k * 5 + 3));
    do @(negedge ref_clk); while (!bus.req && ++wn < 500);
    to_chk(bus.req);
    init_send(8'h5a);
    tgt_pop(8'h5a);
  endtask

  task automatic t_release();
    tgt_req(PH_MSG_IN, 8'h00, 1'h1);
    do @(negedge ref_clk); while (bus.bsy && ++wn < 500);
    to_chk(!bus.bsy);
    repeat (4) @(negedge ref_clk);
    `CHK({bus.sel, bus.req, bus.msg, bus.cd, bus.io, bus.dbp, bus.db, n_conn}, 15'h0000)
  endtask

  task automatic t_busrst(input logic from_tgt);
    t_select();
    @(posedge ref_clk);
    t_rst_req <= from_tgt;
    n_rst_req <= !from_tgt;
    repeat (8) @(negedge ref_clk);
    `CHK({bus.rst, t_rst_seen, bus.bsy, bus.sel, bus.req, bus.db, n_conn}, 14'h3000)
    @(posedge ref_clk);
    t_rst_req <= 1'h0;
    n_rst_req <= 1'h0;
    repeat (8) @(negedge ref_clk);
    `CHK({bus.rst, t_rst_seen}, 2'h0)
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    t_select();
    t_atn();
    for (k = 0; k < 3; k++) t_in(in_ph[k], pat[k]);
    for (k = 0; k < 3; k++) t_out(out_ph[k], ~pat[k], 1'h1);
    t_fifo();
    t_release();
    t_busrst(1'h1);
    t_busrst(1'h0);
    `CHK(perr_seen, 1'h0)
    print_verdict();
  end
endmodule
`default_nettype wire
